// ### rtl/pst_pkg.sv
package pst_pkg;

  // ----------------------------------------------------------------
  // Register indices, byte address is four times the index.
  // ----------------------------------------------------------------
  localparam logic [15:0] PST_IDX_STATUS = 16'h3901;
  localparam logic [15:0] PST_IDX_STATUS2 = 16'h3902;
  localparam logic [15:0] PST_IDX_IRQ_STATUS = 16'h3903;
  localparam logic [15:0] PST_IDX_IRQ_MASK = 16'h3904;

  // ----------------------------------------------------------------
  // First status register fields.
  // ----------------------------------------------------------------
  localparam int PST_B_TX_SEEN = 11;
  localparam int PST_B_RX_SEEN = 10;
  localparam int PST_B_TX_IDLE = 9;
  localparam int PST_B_RX_IDLE = 8;
  localparam int PST_B_FAULT = 7;
  localparam int PST_B_LINK_LL = 2;

  // ----------------------------------------------------------------
  // Second status register fields.
  // ----------------------------------------------------------------
  localparam int PST_B_LINK = 10;
  localparam int PST_B_HIBER = 9;
  localparam int PST_B_RX_LOCK = 8;
  localparam int PST_B_HIBER_SEEN = 7;
  localparam int PST_B_BLK_LOCK = 6;

  // ----------------------------------------------------------------
  // Interrupt event bits.
  // ----------------------------------------------------------------
  localparam int PST_EV_N = 5;
  localparam int PST_EV_TX_IDLE = 0;
  localparam int PST_EV_RX_IDLE = 1;
  localparam int PST_EV_FAULT = 2;
  localparam int PST_EV_LINK_DOWN = 3;
  localparam int PST_EV_HIBER = 4;

  // ----------------------------------------------------------------
  // Reset values.
  // ----------------------------------------------------------------
  localparam logic [15:0] PST_RST_STATUS = 16'h0000;
  localparam logic [PST_EV_N-1:0] PST_RST_MASK = 5'h00;

endpackage

// ### rtl/pst_status.sv
// Design decision made here: the APB slave port.
`timescale 1ns/1ps
module pst_status
  import pst_pkg::*;
#(
  parameter int ADDR_W = 18
) (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [ADDR_W-1:0] paddr,
  input wire logic [31:0] pwdata,
  input wire logic [3:0] pstrb,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire logic tx_lpi,
  input wire logic rx_lpi,
  input wire logic fault,
  input wire logic rx_link_up,
  input wire logic high_error_rate_flag,
  input wire logic block_lock,
  output logic irq
);

  // ----------------------------------------------------------------
  // Elaboration check.
  // ----------------------------------------------------------------
  if (ADDR_W < 18) begin : g_chk
    $error("ADDR_W must be at least 18.");
  end

  typedef struct packed {
    logic [31:0] rdata;
    logic ready;
    logic slverr;
    logic irq;
    logic tx_seen;
    logic rx_seen;
    logic link_ll;
    logic hiber_seen;
    logic [PST_EV_N-1:0] ev;
    logic [PST_EV_N-1:0] mask;
    logic [PST_EV_N-1:0] prev;
  } pst_state_t;

  pst_state_t s_q;
  pst_state_t s_d;

  function automatic logic [15:0] pst_word(input logic [ADDR_W-1:0] a);
    pst_word = a[17:2];
  endfunction

  function automatic logic pst_mapped(input logic [ADDR_W-1:0] a);
    logic [15:0] w;
    w = pst_word(a);
    pst_mapped = (a[1:0] == 2'h0) && (a[ADDR_W-1:2] == (ADDR_W-2)'(w)) &&
                 (w == PST_IDX_STATUS || w == PST_IDX_STATUS2 ||
                  w == PST_IDX_IRQ_STATUS || w == PST_IDX_IRQ_MASK);
  endfunction

  logic [15:0] stat1;
  logic [15:0] stat2;
  logic [PST_EV_N-1:0] cur;
  logic [PST_EV_N-1:0] ev_rise;

  always_comb begin
    stat1 = 16'h0000;
    stat2 = 16'h0000;
    stat1[PST_B_TX_SEEN] = s_q.tx_seen;
    stat1[PST_B_RX_SEEN] = s_q.rx_seen;
    stat1[PST_B_TX_IDLE] = tx_lpi;
    stat1[PST_B_RX_IDLE] = rx_lpi;
    stat1[PST_B_FAULT] = fault;
    stat1[PST_B_LINK_LL] = s_q.link_ll;
    stat2[PST_B_LINK] = rx_link_up;
    stat2[PST_B_HIBER] = high_error_rate_flag;
    stat2[PST_B_RX_LOCK] = block_lock;
    stat2[PST_B_HIBER_SEEN] = s_q.hiber_seen;
    stat2[PST_B_BLK_LOCK] = block_lock;
  end

  always_comb begin
    cur = '0;
    cur[PST_EV_TX_IDLE] = tx_lpi;
    cur[PST_EV_RX_IDLE] = rx_lpi;
    cur[PST_EV_FAULT] = fault;
    cur[PST_EV_LINK_DOWN] = ~rx_link_up;
    cur[PST_EV_HIBER] = high_error_rate_flag;
    ev_rise = cur & ~s_q.prev;
  end

  // ----------------------------------------------------------------
  // Next state.
  // ----------------------------------------------------------------
  always_comb begin
    logic setup;
    logic wr;
    logic rd;
    logic [15:0] w;
    logic [15:0] wd;
    setup = psel && !penable;
    wr = psel && penable && s_q.ready && pwrite && !s_q.slverr;
    rd = psel && penable && s_q.ready && !pwrite && !s_q.slverr;
    w = pst_word(paddr);
    wd = pwdata[15:0];
    s_d = s_q;
    s_d.prev = cur;
    s_d.ready = setup;
    s_d.slverr = setup && !pst_mapped(paddr);
    if (setup) begin
      unique case (w)
        PST_IDX_STATUS: s_d.rdata = {16'h0000, stat1};
        PST_IDX_STATUS2: s_d.rdata = {16'h0000, stat2};
        PST_IDX_IRQ_STATUS: s_d.rdata = {27'h0000000, s_q.ev};
        PST_IDX_IRQ_MASK: s_d.rdata = {27'h0000000, s_q.mask};
        default: s_d.rdata = 32'h00000000;
      endcase
      if (!pst_mapped(paddr)) begin
        s_d.rdata = 32'h00000000;
      end
    end
    if (wr && w == PST_IDX_STATUS && pstrb[1] && !wd[PST_B_TX_SEEN]) begin
      s_d.tx_seen = 1'b0;
    end
    if (wr && w == PST_IDX_STATUS && pstrb[1] && !wd[PST_B_RX_SEEN]) begin
      s_d.rx_seen = 1'b0;
    end
    if (tx_lpi) begin
      s_d.tx_seen = 1'b1;
    end
    if (rx_lpi) begin
      s_d.rx_seen = 1'b1;
    end
    if (wr && w == PST_IDX_STATUS && pstrb[0] && !wd[PST_B_LINK_LL]) begin
      s_d.link_ll = rx_link_up;
    end else begin
      s_d.link_ll = s_q.link_ll & rx_link_up;
    end
    if (rd && w == PST_IDX_STATUS2) begin
      s_d.hiber_seen = 1'b0;
    end
    if (high_error_rate_flag) begin
      s_d.hiber_seen = 1'b1;
    end
    if (wr && w == PST_IDX_IRQ_STATUS && pstrb[0]) begin
      s_d.ev = s_q.ev & ~wd[PST_EV_N-1:0];
    end
    s_d.ev = s_d.ev | ev_rise;
    if (wr && w == PST_IDX_IRQ_MASK && pstrb[0]) begin
      s_d.mask = wd[PST_EV_N-1:0];
    end
    s_d.irq = |(s_d.ev & s_d.mask);
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      s_q <= '0;
      s_q.mask <= PST_RST_MASK;
      s_q.prev <= PST_EV_N'(1 << PST_EV_LINK_DOWN);
    end else begin
      s_q <= s_d;
    end
  end

  assign prdata = s_q.rdata;
  assign pready = s_q.ready;
  assign pslverr = s_q.slverr;
  assign irq = s_q.irq;

endmodule

// ### tb/pst_status_props.sv
`timescale 1ns/1ps
module pst_status_props
  import pst_pkg::*;
#(parameter int ADDR_W = 18) (
  input wire logic pclk, presetn, psel, penable, pwrite,
  input wire logic [ADDR_W-1:0] paddr,
  input wire logic [31:0] pwdata, prdata,
  input wire logic [3:0] pstrb,
  input wire logic pready, pslverr, tx_lpi, rx_lpi, fault, rx_link_up,
  input wire logic high_error_rate_flag, block_lock, irq
);
  default clocking @(posedge pclk); endclocking
  default disable iff (!presetn);
  wire map = paddr[1:0] == 2'h0 && paddr[17:2] >= PST_IDX_STATUS && paddr[17:2] <= PST_IDX_IRQ_MASK;
  wire rd1 = pready && !pwrite && paddr == {PST_IDX_STATUS, 2'h0};
  wire rd2 = pready && !pwrite && paddr == {PST_IDX_STATUS2, 2'h0};
  property p_ans; psel && !penable |=> pready; endproperty
  a_ans: assert property (p_ans) else $error("no answer after setup");
  property p_one; pready |=> !pready; endproperty
  a_one: assert property (p_one) else $error("ready held too long");
  property p_err; pready |-> pslverr == !map; endproperty
  a_err: assert property (p_err) else $error("error flag wrong");
  property p_top; pready |-> prdata[31:16] == 16'h0 && (!pslverr || prdata == 32'h0); endproperty
  a_top: assert property (p_top) else $error("upper read data not zero");
  property p_live; rd1 |-> prdata[9:7] == {$past(tx_lpi), $past(rx_lpi), $past(fault)}; endproperty
  a_live: assert property (p_live) else $error("live bits wrong");
  property p_rsv; rd1 |-> prdata[15:12] == 4'h0 && prdata[6:3] == 4'h0 && prdata[1:0] == 2'h0; endproperty
  a_rsv: assert property (p_rsv) else $error("reserved bits set");
  property p_stk; rd1 && $past(presetn, 3) && $past(tx_lpi, 2) && $past(tx_lpi, 3) |-> prdata[11]; endproperty
  a_stk: assert property (p_stk) else $error("tx sticky not set");
  property p_stkr; rd1 && $past(presetn, 3) && $past(rx_lpi, 2) && $past(rx_lpi, 3) |-> prdata[10]; endproperty
  a_stkr: assert property (p_stkr) else $error("rx sticky not set");
  property p_ll; rd1 && !$past(rx_link_up, 2) |-> !prdata[2]; endproperty
  a_ll: assert property (p_ll) else $error("link drop not latched");
  property p_st2; rd2 |-> prdata[10:8] == {$past(rx_link_up), $past(high_error_rate_flag),
    $past(block_lock)} && prdata[6] == $past(block_lock); endproperty
  a_st2: assert property (p_st2) else $error("second status live bits wrong");
  property p_hs; rd2 && $past(presetn, 3) && $past(high_error_rate_flag, 2) && $past(high_error_rate_flag, 3) |-> prdata[7]; endproperty
  a_hs: assert property (p_hs) else $error("error rate seen not set");
endmodule
bind pst_status pst_status_props #(.ADDR_W(ADDR_W)) u_props (.pclk(pclk), .presetn(presetn),
  .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
  .prdata(prdata), .pstrb(pstrb), .pready(pready), .pslverr(pslverr), .tx_lpi(tx_lpi),
  .rx_lpi(rx_lpi), .fault(fault), .rx_link_up(rx_link_up),
  .high_error_rate_flag(high_error_rate_flag), .block_lock(block_lock), .irq(irq));

// ### tb/tb.sv
`timescale 1ns/1ps
module tb;
  import pst_pkg::*;
  logic pclk = 0, presetn = 0, psel = 0, penable = 0, pwrite = 0, pready, pslverr, irq, er;
  logic [17:0] paddr = '0;
  logic [31:0] pwdata = '0, prdata, rd, w;
  logic [5:0] inp = '0;
  int n_errors = 0, checks = 0, cyc = 0;
  bit tx, rx, f, lk, hb, bl, txs, rxs, ll, hs;
  bit [4:0] ev, mk;
  always #25 pclk = ~pclk;
  pst_status uut (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pstrb(4'hF), .prdata(prdata),
    .pready(pready), .pslverr(pslverr), .tx_lpi(inp[5]), .rx_lpi(inp[4]), .fault(inp[3]),
    .rx_link_up(inp[2]), .high_error_rate_flag(inp[1]), .block_lock(inp[0]), .irq(irq));
  task automatic stop_test;
    $display("checks %0d mismatches %0d", checks, n_errors);
    if (n_errors == 0 && checks > 0) $display("ALL TESTS PASSED");
    else $display("TESTS FAILED");
    $finish;
  endtask
  always @(posedge pclk) begin
    cyc <= cyc + 1;
    if (cyc == 6000) begin
      n_errors++;
      stop_test();
    end
  end
  task automatic chk(input string s, input logic [31:0] e, input logic [31:0] g);
    checks++;
    if (g !== e) begin
      n_errors++;
      $display("[ERR] %s expected %h seen %h", s, e, g);
    end
  endtask
  task automatic apb(input bit wr, input logic [15:0] idx, input logic [31:0] d);
    psel <= 1; penable <= 0; pwrite <= wr; paddr <= {idx, 2'h0}; pwdata <= d;
    @(posedge pclk);
    penable <= 1;
    do begin @(posedge pclk); end while (pready !== 1'b1);
    rd = prdata;
    er = pslverr;
    chk("pslverr", {31'h0, idx < PST_IDX_STATUS || idx > PST_IDX_IRQ_MASK}, {31'h0, er});
  endtask
  task automatic setin(input logic [5:0] v);
    ev |= {v[1] & !hb, !v[2] & lk, v[3] & !f, v[4] & !rx, v[5] & !tx};
    {tx, rx, f, lk, hb, bl} = v;
    txs |= tx; rxs |= rx; hs |= hb;
    if (!lk) ll = 0;
    psel <= 0; penable <= 0; inp <= v;
    repeat (3) @(posedge pclk);
  endtask
  task automatic rd_all;
    apb(0, PST_IDX_STATUS, 0);
    chk("status", {20'h0, txs, rxs, tx, rx, f, 4'h0, ll, 2'h0}, rd);
    apb(0, PST_IDX_STATUS2, 0);
    chk("status2", {21'h0, lk, hb, bl, hs, bl, 6'h0}, rd);
    hs = hb;
    apb(0, PST_IDX_IRQ_STATUS, 0);
    chk("irq_status", {27'h0, ev}, rd);
    chk("irq", {31'h0, |(ev & mk)}, {31'h0, irq});
  endtask
  initial begin
    void'($urandom(12008));
    repeat (8) @(posedge pclk);
    presetn <= 1;
    @(posedge pclk);
    rd_all();
    apb(1, 16'h3905, 32'hFFFF);
    apb(0, 16'h3905, 0);
    chk("unmapped", 0, rd);
    $display("test reset and unmapped done");
    for (int i = 0; i < 40; i++) begin
      setin($urandom);
      w = $urandom;
      apb(1, PST_IDX_STATUS, w);
      if (!w[11]) txs = tx;
      if (!w[10]) rxs = rx;
      if (!w[2]) ll = lk;
      mk = $urandom;
      apb(1, PST_IDX_IRQ_MASK, {27'h0, mk});
      rd_all();
      w = $urandom;
      apb(1, PST_IDX_IRQ_STATUS, w);
      ev &= ~w[4:0];
      $display("test %0d done", i);
    end
    stop_test();
  end
endmodule
